// [core/mcd_decoder.sv]
// motion command decoder with two axes and an axi4-lite register slave
`timescale 1ns/1ps
module mcd_decoder
  import mcd_pkg::*;
#(
  parameter int AXES = 2
) (
  input wire logic mclk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [5:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [5:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [AXES-1:0] servoInPositionN, // in-position pins, low
  input wire logic [AXES-1:0] stopInN, // external stop pins, low
  input wire logic [AXES-1:0] encUp, // encoder count up, same clock
  input wire logic [AXES-1:0] encDown, // encoder count down, same clock
  output logic [AXES-1:0] plusPulseOut, // plus direction pulses
  output logic [AXES-1:0] minusPulseOut // minus direction pulses
);
  ////////////////////////////////////////////////////////////////////
  // register storage
  logic [31:0] dataWrite;
  logic [31:0] dataRead;
  logic [AXES-1:0] axisSel;
  logic [15:0] homeMode [AXES];
  logic [15:0] homeSpeed [AXES];
  logic [15:0] driveSpeed [AXES];
  logic [31:0] pulseTarget [AXES];
  logic [31:0] logicalPos [AXES];
  logic [31:0] realPos [AXES];
  logic [15:0] curSpeed [AXES];
  logic [15:0] curAccel [AXES];
  logic [15:0] status1 [AXES];
  logic [15:0] status2 [AXES];
  logic [AXES-1:0] inPosEnable;
  logic [AXES-1:0] driveFlag;
  logic holdActive;
  ////////////////////////////////////////////////////////////////////
  // axi write channel: take address and data in either order
  logic awHave, wHave;
  logic [5:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic wrFire;
  assign wrFire = awHave && wHave && !s_axi_bvalid;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      awHave <= 1'b0;
      wHave <= 1'b0;
      awAddr <= '0;
      wData <= '0;
      wStrb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHave <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHave <= 1'b0;
        wHave <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awAddr > ADDR_CTRL || awAddr[1:0] != 2'b00) begin
          s_axi_bresp <= RESP_SLVERR;
        end else begin
          s_axi_bresp <= RESP_OKAY;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !awHave && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !wHave && !(s_axi_wvalid && s_axi_wready);
    end
  end
  ////////////////////////////////////////////////////////////////////
  // command decode, one strobe per accepted command word
  logic cmdStrobe;
  logic [7:0] cmdCode;
  logic [AXES-1:0] cmdAxes;
  assign cmdStrobe = wrFire && awAddr == ADDR_CMD && wStrb[0];
  assign cmdCode = wData[7:0];
  assign cmdAxes = wData[CMD_AXIS_LSB +: AXES];
  // selected axis for status reads; x wins when both set
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      axisSel <= {{(AXES-1){1'b0}}, 1'b1};
    end else if (cmdStrobe && cmdCode == CMD_NOP) begin // (R1)
      axisSel <= cmdAxes;
    end
  end
  // data write register and in-position enables
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dataWrite <= '0;
      inPosEnable <= '0;
    end else if (wrFire) begin
      if (awAddr == ADDR_DLO_W) begin
        dataWrite[15:0] <= wData[15:0];
      end else if (awAddr == ADDR_DHI_W) begin
        dataWrite[31:16] <= wData[15:0];
      end else if (awAddr == ADDR_CTRL) begin
        inPosEnable <= wData[AXES-1:0];
      end
    end
  end
  // hold flag: set by 24h, cleared by 25h
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      holdActive <= 1'b0;
    end else if (cmdStrobe && cmdCode == CMD_HOLD) begin // (R20)
      holdActive <= 1'b1;
    end else if (cmdStrobe && cmdCode == CMD_RELEASE) begin // (R21)
      holdActive <= 1'b0;
    end
  end
  // read command: lowest assigned axis supplies the data
  logic [AXES-1:0] rdPick;
  assign rdPick = cmdAxes & (~cmdAxes + 1'b1); // (R7)
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      dataRead <= '0;
    end else if (cmdStrobe) begin
      for (int a = 0; a < AXES; a++) begin
        if (rdPick[a]) begin
          if (cmdCode == CMD_RD_LOGPOS) begin // (R4) (R8)
            dataRead <= logicalPos[a];
          end else if (cmdCode == CMD_RD_REALPOS) begin // (R8)
            dataRead <= realPos[a]; // (R5)
          end else if (cmdCode == CMD_RD_SPEED) begin // (R9)
            dataRead <= {16'h0000, curSpeed[a]};
          end else if (cmdCode == CMD_RD_ACCEL) begin // (R10)
            dataRead <= {16'h0000, curAccel[a]};
          end
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // per-axis drive engines
  logic [AXES-1:0] inPosSync;
  logic [AXES-1:0] stopSync;
  logic [AXES-1:0] outPlus, outMinus;
  for (genvar g = 0; g < AXES; g++) begin : gAxis
    logic [2:0] ipSh, stSh;
    mcd_axis_type state;
    logic dirMinus, contMode, pendMinus, pendCont;
    logic [31:0] sent;
    logic [15:0] div;
    logic pulseLvl, pulseEdge, mine;
    assign mine = cmdStrobe && cmdAxes[g];
    // pin sync: change counts when second and third agree
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        ipSh <= 3'b111;
        stSh <= 3'b111;
        inPosSync[g] <= 1'b0;
        stopSync[g] <= 1'b0;
      end else begin
        ipSh <= {ipSh[1:0], servoInPositionN[g]};
        stSh <= {stSh[1:0], stopInN[g]};
        if (ipSh[1] == ipSh[2]) begin
          inPosSync[g] <= !ipSh[2];
        end
        if (stSh[1] == stSh[2]) begin
          stopSync[g] <= !stSh[2];
        end
      end
    end
    // parameters latched per axis
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        homeMode[g] <= '0;
        homeSpeed[g] <= HOME_SPEED_MIN;
        pulseTarget[g] <= '0;
        driveSpeed[g] <= SPEED_RESET;
      end else if (mine) begin
        if (cmdCode == CMD_HOME_MODE) begin // (R2)
          homeMode[g] <= dataWrite[15:0];
        end else if (cmdCode == CMD_HOME_SPEED) begin // (R3)
          if (dataWrite[15:0] >= HOME_SPEED_MIN &&
              dataWrite[15:0] <= HOME_SPEED_MAX) begin
            homeSpeed[g] <= dataWrite[15:0];
          end
        end else if (cmdCode == CMD_PULSES) begin // (R23)
          pulseTarget[g] <= dataWrite;
        end
      end else if (wrFire && awAddr == ADDR_SPEED && axisSel[g]) begin
        driveSpeed[g] <= wData[15:0];
      end
    end
    // drive state machine; undefined codes fall through untouched
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        state <= AX_IDLE;
        dirMinus <= 1'b0;
        contMode <= 1'b0;
        pendMinus <= 1'b0;
        pendCont <= 1'b0;
      end else begin
        case (state)
          AX_IDLE: begin
            if (mine && cmdCode >= CMD_FIX_PLUS &&
                cmdCode <= CMD_CONT_MINUS) begin // (R11) (R24)
              pendMinus <= cmdCode[0];
              pendCont <= cmdCode[1];
              dirMinus <= cmdCode[0];
              contMode <= cmdCode[1];
              state <= holdActive ? AX_HELD : AX_RUN; // (R20)
            end
          end
          AX_HELD: begin
            if (cmdStrobe && cmdCode == CMD_RELEASE) begin // (R21)
              dirMinus <= pendMinus;
              contMode <= pendCont;
              state <= AX_RUN;
            end
          end
          AX_RUN: begin
            // live count compare; a stop waits for the low half
            if ((contMode && stopSync[g] && !pulseLvl) ||
                (!contMode && sent >= pulseTarget[g])) begin // (R18)
              state <= inPosEnable[g] ? AX_INPOS : AX_IDLE;
            end
          end
          AX_INPOS: begin
            if (inPosSync[g]) begin // (R13)
              state <= AX_IDLE;
            end
          end
          default: state <= AX_IDLE;
        endcase
      end
    end
    // pulse generator: fixed-rate square wave while running
    assign pulseEdge = state == AX_RUN && div == PULSE_HALF && pulseLvl &&
                       (contMode || sent < pulseTarget[g]);
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        div <= '0;
        pulseLvl <= 1'b0;
        sent <= '0;
        outPlus[g] <= 1'b0;
        outMinus[g] <= 1'b0;
      end else if (state == AX_RUN) begin
        if (div == PULSE_HALF) begin
          div <= '0;
          pulseLvl <= !pulseLvl;
        end else begin
          div <= div + 16'h0001;
        end
        if (pulseEdge) begin
          sent <= sent + 32'h00000001;
        end
        outPlus[g] <= pulseLvl && !dirMinus; // (R15)
        outMinus[g] <= pulseLvl && dirMinus; // (R16)
      end else begin
        div <= '0;
        pulseLvl <= 1'b0;
        sent <= '0;
        outPlus[g] <= 1'b0;
        outMinus[g] <= 1'b0;
      end
    end
    // counters and live readings
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        logicalPos[g] <= '0;
        realPos[g] <= '0;
        curSpeed[g] <= '0;
        curAccel[g] <= '0;
      end else begin
        if (pulseEdge) begin // (R17)
          logicalPos[g] <= dirMinus ? logicalPos[g] - 32'h00000001
                                    : logicalPos[g] + 32'h00000001;
        end
        if (encUp[g] && !encDown[g]) begin
          realPos[g] <= realPos[g] + 32'h00000001;
        end else if (encDown[g] && !encUp[g]) begin
          realPos[g] <= realPos[g] - 32'h00000001;
        end
        curSpeed[g] <= state == AX_RUN ? driveSpeed[g] : 16'h0000; // (R9)
        curAccel[g] <= '0; // constant speed profile only
      end
    end
    // finish bits set on stop, cleared by 25h; set wins
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        status1[g] <= '0;
        status2[g] <= '0;
      end else begin
        if (cmdStrobe && cmdCode == CMD_RELEASE) begin // (R22)
          status1[g][15:FINISH_LSB] <= '0;
          status2[g][HOME_ERR_BIT] <= 1'b0;
        end
        if (state == AX_RUN && contMode && stopSync[g]) begin
          status1[g][FINISH_LSB] <= 1'b1;
        end
      end
    end
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        driveFlag[g] <= 1'b0;
      end else begin
        driveFlag[g] <= state == AX_RUN || state == AX_INPOS; // (R12)
      end
    end
  end
  assign plusPulseOut = outPlus;
  assign minusPulseOut = outMinus;
  ////////////////////////////////////////////////////////////////////
  // axi read channel; x axis shown when both selected
  logic [31:0] next_rdata;
  int sel;
  always_comb begin
    sel = 0;
    for (int a = AXES - 1; a >= 0; a--) begin
      if (axisSel[a]) begin
        sel = a;
      end
    end
    next_rdata = '0;
    if (s_axi_araddr == ADDR_MAIN_ST) begin
      next_rdata = {{(32-AXES){1'b0}}, driveFlag};
    end else if (s_axi_araddr == ADDR_ST1) begin
      next_rdata = {16'h0000, status1[sel]};
    end else if (s_axi_araddr == ADDR_ST2) begin
      next_rdata = {16'h0000, status2[sel]};
    end else if (s_axi_araddr == ADDR_DLO_R) begin
      next_rdata = {16'h0000, dataRead[15:0]};
    end else if (s_axi_araddr == ADDR_DHI_R) begin
      next_rdata = {16'h0000, dataRead[31:16]};
    end else if (s_axi_araddr == ADDR_HOME_MODE) begin
      next_rdata = {16'h0000, homeMode[sel]};
    end else if (s_axi_araddr == ADDR_HOME_SPEED) begin
      next_rdata = {16'h0000, homeSpeed[sel]};
    end else if (s_axi_araddr == ADDR_SPEED) begin
      next_rdata = {16'h0000, driveSpeed[sel]};
    end else if (s_axi_araddr == ADDR_CTRL) begin
      next_rdata = {{(32-AXES){1'b0}}, inPosEnable};
    end
  end
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= (s_axi_araddr > ADDR_CTRL ||
                        s_axi_araddr[1:0] != 2'b00) ? RESP_SLVERR : RESP_OKAY;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////
  // checks
  chk_nop_axis: assert property (@(posedge mclk) disable iff (!arst_n)
    cmdStrobe && cmdCode == CMD_NOP |=> axisSel == $past(cmdAxes)) // (R1)
    else $error("axis select not updated by nop");
  chk_hold_start: assert property (@(posedge mclk) disable iff (!arst_n)
    cmdStrobe && cmdCode == CMD_HOLD |=> holdActive) // (R20)
    else $error("hold not registered");
  chk_release: assert property (@(posedge mclk) disable iff (!arst_n)
    cmdStrobe && cmdCode == CMD_RELEASE |=> !holdActive) // (R21)
    else $error("hold not released");
  chk_flag_idle: assert property (@(posedge mclk) disable iff (!arst_n)
    driveFlag == '0 |-> plusPulseOut == '0 && minusPulseOut == '0) // (R12)
    else $error("pulses without drive flag");
  chk_speed_zero: assert property (@(posedge mclk) disable iff (!arst_n)
    !driveFlag[0] && $past(!driveFlag[0]) |-> curSpeed[0] == 16'h0000) // (R9)
    else $error("speed nonzero while idle");
  chk_no_both: assert property (@(posedge mclk) disable iff (!arst_n)
    (plusPulseOut & minusPulseOut) == '0) // (R15)
    else $error("both directions pulsing");
  chk_clear_fin: assert property (@(posedge mclk) disable iff (!arst_n)
    cmdStrobe && cmdCode == CMD_RELEASE && !stopSync[0] |=>
    status1[0][15:FINISH_LSB] == '0 && !status2[0][HOME_ERR_BIT]) // (R22)
    else $error("finish status not cleared");
  chk_home_speed: assert property (@(posedge mclk) disable iff (!arst_n)
    homeSpeed[0] >= HOME_SPEED_MIN && homeSpeed[0] <= HOME_SPEED_MAX) // (R3)
    else $error("home speed out of range");
endmodule

// [core/mcd_pkg.sv]
// constants and types shared by the motion command decoder
//
// Contract
// (R1) code 0fh only switches selected axis
// (R2) code 60h latches low data as mode
// (R3) code 61h stores home search speed
// (R4) read commands load read data registers
// (R5) read data binary, negatives two's complement
// (R6) host waits 250 ns before reading data
// (R7) both axes assigned: read returns x axis
// (R8) 10h logical, 11h real position counter
// (R9) 12h current speed, zero when idle
// (R10) 13h current accel, undefined when idle
// (R11) drive command starts every assigned axis
// (R12) drive flag high while axis drives
// (R13) in-position enabled: flag waits for input
// (R14) host spaces commands by 250 ns
// (R15) 20h fixed pulses on plus output
// (R16) 21h fixed pulses on minus output
// (R17) logical counter follows plus and minus pulses
// (R18) 22h/23h continuous until stop
// (R19) host sets parameters before driving
// (R20) 24h holds later drive starts only
// (R21) 25h releases hold, starts held drives
// (R22) 25h clears finish and home error bits
// (R23) pulse count 06h, changeable while driving
// (R24) undefined codes are ignored
package mcd_pkg;
  localparam logic [7:0] CMD_PULSES = 8'h06;
  localparam logic [7:0] CMD_NOP = 8'h0f;
  localparam logic [7:0] CMD_RD_LOGPOS = 8'h10;
  localparam logic [7:0] CMD_RD_REALPOS = 8'h11;
  localparam logic [7:0] CMD_RD_SPEED = 8'h12;
  localparam logic [7:0] CMD_RD_ACCEL = 8'h13;
  localparam logic [7:0] CMD_FIX_PLUS = 8'h20;
  localparam logic [7:0] CMD_FIX_MINUS = 8'h21;
  localparam logic [7:0] CMD_CONT_PLUS = 8'h22;
  localparam logic [7:0] CMD_CONT_MINUS = 8'h23;
  localparam logic [7:0] CMD_HOLD = 8'h24;
  localparam logic [7:0] CMD_RELEASE = 8'h25;
  localparam logic [7:0] CMD_HOME_MODE = 8'h60;
  localparam logic [7:0] CMD_HOME_SPEED = 8'h61;
  // register byte addresses on the bus
  localparam logic [5:0] ADDR_CMD = 6'h00;
  localparam logic [5:0] ADDR_DLO_W = 6'h04;
  localparam logic [5:0] ADDR_DHI_W = 6'h08;
  localparam logic [5:0] ADDR_MAIN_ST = 6'h0c;
  localparam logic [5:0] ADDR_ST1 = 6'h10;
  localparam logic [5:0] ADDR_ST2 = 6'h14;
  localparam logic [5:0] ADDR_DLO_R = 6'h18;
  localparam logic [5:0] ADDR_DHI_R = 6'h1c;
  localparam logic [5:0] ADDR_HOME_MODE = 6'h20;
  localparam logic [5:0] ADDR_HOME_SPEED = 6'h24;
  localparam logic [5:0] ADDR_SPEED = 6'h28;
  localparam logic [5:0] ADDR_CTRL = 6'h2c;
  // command word and status register fields
  localparam int CMD_AXIS_LSB = 8;
  localparam int FINISH_LSB = 8;
  localparam int HOME_ERR_BIT = 7;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [15:0] HOME_SPEED_MIN = 16'h0001;
  localparam logic [15:0] HOME_SPEED_MAX = 16'h1f40;
  localparam logic [15:0] SPEED_RESET = 16'h0001;
  // pulse period divider (cycles per pulse half period, minus one)
  localparam logic [15:0] PULSE_HALF = 16'h0004;
  typedef enum {AX_IDLE, AX_HELD, AX_RUN, AX_INPOS} mcd_axis_type;
endpackage

// [testbench/mcd_host_model.sv]
// host processor model: axi4-lite master with command helpers
`timescale 1ns/1ps
module mcd_host_model
  import mcd_pkg::*;
(
  input wire logic mclk, // system clock
  output logic [5:0] awaddr, // write address
  output logic awvalid, // write address valid
  input wire logic awready, // write address ready
  output logic [31:0] wdata, // write data
  output logic [3:0] wstrb, // write strobes
  output logic wvalid, // write data valid
  input wire logic wready, // write data ready
  input wire logic [1:0] bresp, // write response
  input wire logic bvalid, // write response valid
  output logic bready, // write response ready
  output logic [5:0] araddr, // read address
  output logic arvalid, // read address valid
  input wire logic arready, // read address ready
  input wire logic [31:0] rdata, // read data
  input wire logic [1:0] rresp, // read response
  input wire logic rvalid, // read data valid
  output logic rready // read data ready
);
  // 250 ns at 8 ns a cycle, rounded up
  localparam int CMD_GAP = 32;
  logic [1:0] lastResp; // response code of the last write
  // bus idle until the first request
  initial begin
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
  end
  ////////////////////////////////////////////////////////////////////////
  // one write; address and data released as each is taken
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (aw && awready) begin
        aw = 1'b0;
        awvalid <= 1'b0;
      end
      if (w && wready) begin
        w = 1'b0;
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    lastResp = bresp;
    bready <= 1'b0;
    // a free edge so no strobe is set twice in one step
    @(posedge mclk);
  endtask
  // one read; data taken at the edge that sees rvalid
  task automatic rd(input logic [5:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask
  // command word, then the settling gap before anything else
  task automatic cmd(input logic [7:0] code, input logic [1:0] axes);
    wr(ADDR_CMD, {22'h0, axes, code});
    repeat (CMD_GAP) @(posedge mclk);
  endtask
  // 32-bit operand split over the two data write registers
  task automatic setData(input logic [31:0] v);
    wr(ADDR_DLO_W, {16'h0, v[15:0]});
    wr(ADDR_DHI_W, {16'h0, v[31:16]});
  endtask
endmodule

// [testbench/motion_command_decoder_test.sv]
// self-checking bench for the motion command decoder
`timescale 1ns/1ps
module motion_command_decoder_test
  import mcd_pkg::*;
;
  logic mclk;
  logic arst_n;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [1:0] bresp, rresp, inPosN, stopN, encUp, encDown, plusP, minusP;
  logic [1:0] plusQ, minusQ;
  int plusCnt [2], minusCnt [2];
  int badCount;
  int testsRun;
  ////////////////////////////////////////////////////////////////////////
  mcd_decoder u_mcd_decoder (.mclk(mclk), .arst_n(arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .servoInPositionN(inPosN), .stopInN(stopN),
    .encUp(encUp), .encDown(encDown), .plusPulseOut(plusP),
    .minusPulseOut(minusP));
  mcd_host_model u_mcd_host_model (.mclk(mclk), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // clock and pulse edge counters
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    plusQ <= plusP;
    minusQ <= minusP;
    for (int i = 0; i < 2; i++) begin
      if (plusP[i] === 1'b1 && plusQ[i] === 1'b0) plusCnt[i]++;
      if (minusP[i] === 1'b1 && minusQ[i] === 1'b0) minusCnt[i]++;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rdReg(input logic [5:0] a, output logic [31:0] v);
    logic [1:0] r;
    u_mcd_host_model.rd(a, v, r);
  endtask
  // read command, then the two halves of the answer
  task automatic rdCmd(input logic [7:0] c, input logic [1:0] ax,
                       output logic [31:0] v);
    logic [31:0] lo, hi;
    u_mcd_host_model.cmd(c, ax);
    rdReg(ADDR_DLO_R, lo);
    rdReg(ADDR_DHI_R, hi);
    v = {hi[15:0], lo[15:0]};
  endtask
  // polling is bounded only by the watchdog
  task automatic waitIdle(input logic [1:0] m);
    logic [31:0] v;
    do rdReg(ADDR_MAIN_ST, v); while ((v[1:0] & m) !== 2'b00);
  endtask
  task automatic clrCnt();
    plusCnt = '{0, 0};
    minusCnt = '{0, 0};
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic tFixed();
    logic [31:0] v;
    u_mcd_host_model.setData(32'd20);
    u_mcd_host_model.cmd(CMD_PULSES, 2'b01);
    u_mcd_host_model.cmd(CMD_FIX_PLUS, 2'b01);
    rdReg(ADDR_MAIN_ST, v);
    chk("drive flag", v[1:0], 32'h1);
    rdCmd(CMD_RD_SPEED, 2'b01, v);
    chk("speed run", v, {16'h0, SPEED_RESET});
    waitIdle(2'b11);
    chk("plus count", plusCnt[0], 32'd20);
    chk("minus count", minusCnt[0], 32'd0);
    rdCmd(CMD_RD_LOGPOS, 2'b01, v);
    chk("logical x", v, 32'd20);
    rdCmd(CMD_RD_SPEED, 2'b01, v);
    chk("speed idle", v, 32'h0);
  endtask
  task automatic tMinus();
    logic [31:0] v;
    u_mcd_host_model.cmd(CMD_PULSES, 2'b10);
    u_mcd_host_model.cmd(CMD_FIX_MINUS, 2'b10);
    // count raised while the drive runs
    u_mcd_host_model.setData(32'd24);
    u_mcd_host_model.cmd(CMD_PULSES, 2'b10);
    waitIdle(2'b11);
    chk("minus count", minusCnt[1], 32'd24);
    rdCmd(CMD_RD_LOGPOS, 2'b10, v);
    chk("logical y", v, 32'hffffffe8);
    rdCmd(CMD_RD_LOGPOS, 2'b11, v);
    chk("both axes", v, 32'd20);
  endtask
  task automatic tEncoder();
    logic [31:0] v;
    encUp <= 2'b01;
    encDown <= 2'b10;
    repeat (2) @(posedge mclk);
    encUp <= 2'b00;
    encDown <= 2'b00;
    rdCmd(CMD_RD_REALPOS, 2'b01, v);
    chk("real x", v, 32'd2);
    rdCmd(CMD_RD_REALPOS, 2'b10, v);
    chk("real y", v, 32'hfffffffe);
  endtask
  // no-op and unknown codes leave drives and counters alone
  task automatic tIgnore();
    logic [31:0] v;
    logic [7:0] codes [2];
    codes = '{CMD_NOP, 8'h55};
    foreach (codes[i]) begin
      u_mcd_host_model.cmd(codes[i], 2'b11);
      rdReg(ADDR_MAIN_ST, v);
      chk("idle flags", v[1:0], 32'h0);
      rdCmd(CMD_RD_LOGPOS, 2'b01, v);
      chk("logical kept", v, 32'd20);
    end
  endtask
  task automatic tHome();
    logic [31:0] v;
    u_mcd_host_model.setData(32'h1234);
    u_mcd_host_model.cmd(CMD_HOME_MODE, 2'b01);
    rdReg(ADDR_HOME_MODE, v);
    chk("home mode", v[15:0], 32'h1234);
    for (int i = 0; i < 2; i++) begin
      u_mcd_host_model.setData(i == 0 ? 32'd8000 : 32'd8001);
      u_mcd_host_model.cmd(CMD_HOME_SPEED, 2'b01);
      rdReg(ADDR_HOME_SPEED, v);
      chk("home speed", v[15:0], {16'h0, HOME_SPEED_MAX});
    end
  endtask
  task automatic tHold();
    logic [31:0] v;
    clrCnt();
    u_mcd_host_model.cmd(CMD_HOLD, 2'b11);
    u_mcd_host_model.cmd(CMD_FIX_PLUS, 2'b11);
    rdReg(ADDR_MAIN_ST, v);
    chk("held flags", v[1:0], 32'h0);
    chk("held pulses", plusCnt[0], 32'd0);
    u_mcd_host_model.cmd(CMD_RELEASE, 2'b11);
    rdReg(ADDR_MAIN_ST, v);
    chk("released", v[1:0], 32'h3);
    waitIdle(2'b11);
    chk("x pulses", plusCnt[0], 32'd20);
    chk("y pulses", plusCnt[1], 32'd24);
  endtask
  task automatic tCont();
    logic [31:0] v;
    u_mcd_host_model.cmd(CMD_CONT_MINUS, 2'b01);
    u_mcd_host_model.cmd(CMD_HOLD, 2'b01);
    rdReg(ADDR_MAIN_ST, v);
    chk("cont runs", v[1:0], 32'h1);
    stopN <= 2'b10;
    waitIdle(2'b01);
    stopN <= 2'b11;
    u_mcd_host_model.cmd(CMD_NOP, 2'b01);
    rdReg(ADDR_ST1, v);
    chk("finish set", v[15:8] != 8'h0, 32'h1);
    u_mcd_host_model.cmd(CMD_RELEASE, 2'b01);
    rdReg(ADDR_ST1, v);
    chk("finish clr", v[15:8], 32'h0);
  endtask
  task automatic tInPos();
    logic [31:0] v;
    logic [1:0] r;
    inPosN <= 2'b11;
    u_mcd_host_model.wr(ADDR_CTRL, 32'h1);
    u_mcd_host_model.setData(32'd2);
    u_mcd_host_model.cmd(CMD_PULSES, 2'b01);
    u_mcd_host_model.cmd(CMD_FIX_PLUS, 2'b01);
    repeat (80) @(posedge mclk);
    rdReg(ADDR_MAIN_ST, v);
    chk("inpos wait", v[1:0], 32'h1);
    inPosN <= 2'b00;
    repeat (10) @(posedge mclk);
    rdReg(ADDR_MAIN_ST, v);
    chk("inpos done", v[1:0], 32'h0);
    u_mcd_host_model.rd(6'h30, v, r);
    chk("bad address", r, {30'h0, RESP_SLVERR});
    u_mcd_host_model.wr(6'h31, 32'h0);
    chk("bad write", u_mcd_host_model.lastResp, {30'h0, RESP_SLVERR});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    badCount = 0;
    testsRun = 0;
    clrCnt();
    {inPosN, encUp, encDown} = '0;
    stopN = 2'b11;
    arst_n = 1'b0;
    repeat (16) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    chk("pulses idle", {plusP, minusP}, 32'h0);
    tFixed();
    tMinus();
    tEncoder();
    tIgnore();
    tHome();
    tHold();
    tCont();
    tInPos();
    finish_test();
  end
  // watchdog far beyond the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge mclk);
    badCount++;
    finish_test();
  end
endmodule
